// ==== logic/pacr_cfg.svh ====
// Register map, field positions and reset values of the synthesizer control bank.
// Assumes it is included by bare name from the package and the design file.
`ifndef PACR_CFG_SVH
`define PACR_CFG_SVH

// Printed offsets are register indices; the byte address is four times the index.
`define PACR_IDX_ANALOG   8'h08
`define PACR_IDX_PUMP     8'h09
`define PACR_IDX_AUX      8'h0a
`define PACR_IDX_DET      8'h0b

// Implemented widths of the four registers.
`define PACR_W_ANALOG     24
`define PACR_W_PUMP       24
`define PACR_W_AUX        17
`define PACR_W_DET        24

// Reset values, one per register.
`define PACR_RST_ANALOG   24'hc1beff
`define PACR_RST_PUMP     24'h40050a
`define PACR_RST_AUX      17'h00000
`define PACR_RST_DET      24'h0f8061

// Mask of bits that hold storage; reserved bits 18 and 20 of the analog bank stay stored.
`define PACR_MASK_ANALOG  24'hffffff
`define PACR_MASK_PUMP    24'hffffff
`define PACR_MASK_AUX     17'h1ffff
`define PACR_MASK_DET     24'hffffff

// Analog enable bank fields.
`define PACR_AN_BIAS      0
`define PACR_AN_PUMP      1
`define PACR_AN_DET       2
`define PACR_AN_REFBUF    3
`define PACR_AN_VCOBUF    4
`define PACR_AN_PAD       5
`define PACR_AN_DIVCLK    7
`define PACR_AN_PSCLK     9
`define PACR_AN_PSBIAS    10
`define PACR_AN_OPAMP     11
`define PACR_AN_RFBUF_LO  12
`define PACR_AN_RESYN_LO  15
`define PACR_AN_DIV2      19
`define PACR_AN_HIREF     21

// Pump gain fields.
`define PACR_PU_DN_LO     0
`define PACR_PU_UP_LO     7
`define PACR_PU_OFS_LO    14
`define PACR_PU_OFS_UP    21
`define PACR_PU_OFS_DN    22
`define PACR_PU_HIGAIN    23

// Auxiliary trigger fields.
`define PACR_AX_NOTRIG    12
`define PACR_AX_BYPASS    16

// Detector fields.
`define PACR_DT_DELAY_LO  0
`define PACR_DT_SHORT     3
`define PACR_DT_FLIP      4
`define PACR_DT_UP_EN     5
`define PACR_DT_DN_EN     6
`define PACR_DT_SLIP_LO   7
`define PACR_DT_FRC_UP    9
`define PACR_DT_FRC_DN    10
`define PACR_DT_MIDRAIL   11
`define PACR_DT_PSB_LO    12
`define PACR_DT_OPB_LO    15
`define PACR_DT_GATE_LO   17
`define PACR_DT_PW_LO     20

// Bus answer codes.
`define PACR_RESP_OKAY    2'h0
`define PACR_RESP_SLVERR  2'h2

`endif

// ==== logic/pacr_pkg.sv ====
// Types shared by the synthesizer control bank.
// Assumes pacr_cfg.svh is on the include path.
`default_nettype none
`include "pacr_cfg.svh"

package pacr_pkg;

	// Slip guard thresholds in the detector bank.
	typedef enum logic [1:0] {
		SLIP_OFF,
		SLIP_2NS,
		SLIP_4NS,
		SLIP_6NS
	} pacr_slip_e;

	// Counter clock gating codes.
	typedef enum logic [1:0] {
		GATE_BELOW_32,
		GATE_BELOW_128,
		GATE_BELOW_1023,
		GATE_ALL_ON
	} pacr_gate_e;

	// Write channel progress of the bus slave.
	typedef enum logic [1:0] {
		WR_IDLE,
		WR_RESP
	} pacr_wr_e;

	// Settings that drive the analog sections.
	typedef struct packed {
		logic       bias_enable;
		logic       pump_enable;
		logic       phase_detector_enable;
		logic       ref_buffer_enable;
		logic       vco_buffer_enable;
		logic       divided_clock_to_logic_enable;
		logic       prescaler_clock_enable;
		logic       prescaler_bias_enable;
		logic       pump_opamp_enable;
		logic [2:0] rf_buffer_bias;
		logic [2:0] resync_bias;
		logic       half_band_divider_enable;
		logic       high_freq_reference;
		logic [6:0] pump_down_gain;
		logic [6:0] pump_up_gain;
		logic [6:0] pump_offset;
		logic       pump_offset_up;
		logic       pump_offset_down;
		logic       high_gain_pump_mode;
		logic       ref_divider_bypass;
		logic [2:0] detector_reset_delay;
		logic       detector_inputs_shorted;
		logic       detector_polarity_flip;
		logic       detector_up_out;
		logic       detector_down_out;
		logic [1:0] slip_guard_mode;
		logic       pump_mid_rail;
		logic [2:0] prescaler_bias_level;
		logic [1:0] opamp_bias;
		logic [1:0] main_counter_gating;
		logic [1:0] divider_pulse_width;
	} pacr_analog_s;

	// Complete state of the register bank and its bus slave.
	typedef struct packed {
		logic [23:0] analog;
		logic [23:0] pump;
		logic [16:0] aux;
		logic [23:0] det;
		pacr_wr_e    wr_state;
		logic        aw_held;
		logic        w_held;
		logic [7:0]  aw_idx;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        aux_trigger;
	} pacr_state_s;

endpackage

`default_nettype wire

// ==== logic/pacr_regs.sv ====
// Control register bank of a fractional-N synthesizer reached over AXI4-Lite.
// Assumes a single 100 MHz clock and a synchronous active-low reset from the system.
//
// Behaviour
// - Bits 0..4 enable bias, pump, detector, reference buffer, VCO buffer; reset one.
// - Clearing bit 5 turns off the lock/serial output pin; reset one.
// - Three-bit RF buffer and resync fields reset to 3; 0 off, 1 low, 7 high.
// - Bit 19 enables the high-band divide-by-two path; reset zero.
// - Pump bits 6:0 hold the down gain, 20 uA a step, reset ten.
// - Pump bits 13:7 hold the up gain, 20 uA a step, reset ten.
// - Pump bits 20:14 hold offset current, 5 uA a step, reset zero.
// - Bit 21 applies offset upward, bit 22 downward; resets 0 and 1.
// - Pump bit 23 selects high-gain low-noise mode, needing the opamp; reset zero.
// - Aux bit 12 suppresses the auxiliary serial transfer on a register 5 write.
// - Aux bit 16 forces the reference divider bypass; reset zero.
// - Detector bits 2:0 select the reset path delay; reset one.
// - Detector bit 3 shorts both detector inputs, test only; reset zero.
// - Detector bit 4 inverts detector polarity; reset zero.
// - Detector bits 5 and 6 enable up and down outputs; forcing also acts.
// - Detector bits 8:7 set slip guard threshold 2, 4 or 6 ns; 0 off.
// - Bits 9, 10, 11 force pump up, pump down, or mid rail; test only.
// - Detector bits 14:12 set prescaler bias level; reset zero.
// - Detector bits 18:17 gate the main counter clock; reset three keeps all on.
// - Detector bits 21:20 set divider pulse width; reset zero.
//
// The implementer's own choice: the AXI4-Lite register port.

`timescale 1ns/1ps
`default_nettype none
`include "pacr_cfg.svh"

module pacr_regs (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// Write address channel.
	input  wire logic [31:0]          s_axi_awaddr,
	input  wire logic [2:0]           s_axi_awprot,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	// Write data channel.
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	// Write response channel.
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	// Read address channel.
	input  wire logic [31:0]          s_axi_araddr,
	input  wire logic [2:0]           s_axi_arprot,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	// Read data channel.
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// Settings toward the analog sections.
	output pacr_pkg::pacr_analog_s    analog_settings,
	output logic                      output_pad_enable,
	// Write to synthesizer register 5 from the serial front end, one-cycle pulse.
	input  wire logic                 freq_reg_write,
	output logic                      auxiliary_serial_port_start
);

	pacr_pkg::pacr_state_s st_q;
	pacr_pkg::pacr_state_s st_d;

	// Turns a byte address into a register index; unaligned low bits are ignored.
	function automatic logic [7:0] addr_to_idx(input logic [31:0] addr);
		return addr[9:2];
	endfunction

	// Tells whether an index names one of the four implemented registers.
	function automatic logic idx_mapped(input logic [7:0] idx);
		return (idx == `PACR_IDX_ANALOG) || (idx == `PACR_IDX_PUMP) ||
			(idx == `PACR_IDX_AUX) || (idx == `PACR_IDX_DET);
	endfunction

	// Merges write data into a 24-bit register under byte strobes.
	function automatic logic [23:0] merge24(input logic [23:0] old, input logic [31:0] wd,
			input logic [3:0] strb, input logic [23:0] mask);
		logic [23:0] res;
		res = old;
		for (int b = 0; b < 3; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return res & mask;
	endfunction

	// Reads a register by index; upper bits above the register width read as zero.
	function automatic logic [31:0] read_idx(input logic [7:0] idx,
			input pacr_pkg::pacr_state_s s);
		case (idx)
			`PACR_IDX_ANALOG: return {8'h00, s.analog};
			`PACR_IDX_PUMP:   return {8'h00, s.pump};
			`PACR_IDX_AUX:    return {15'h0000, s.aux};
			`PACR_IDX_DET:    return {8'h00, s.det};
			default:          return 32'h00000000;
		endcase
	endfunction

	logic        aw_fire;
	logic        w_fire;
	logic        ar_fire;
	logic [23:0] aux_wide;

	// Address and data are each accepted once while no response is pending.
	assign s_axi_awready = (st_q.wr_state == pacr_pkg::WR_IDLE) && !st_q.aw_held;
	assign s_axi_wready  = (st_q.wr_state == pacr_pkg::WR_IDLE) && !st_q.w_held;
	// A new read is only taken when the previous answer has left.
	assign s_axi_arready = !st_q.rvalid;
	assign aw_fire       = s_axi_awvalid && s_axi_awready;
	assign w_fire        = s_axi_wvalid && s_axi_wready;
	assign ar_fire       = s_axi_arvalid && s_axi_arready;
	assign aux_wide      = {7'h00, st_q.aux};

	// Next-state logic for the bus slave and the register contents.
	always_comb begin
		logic [7:0]  widx;
		logic [31:0] wdat;
		logic [3:0]  wstb;
		logic        have_aw;
		logic        have_w;
		widx    = 8'h00;
		wdat    = 32'h00000000;
		wstb    = 4'h0;
		have_aw = 1'b0;
		have_w  = 1'b0;
		st_d    = st_q;
		st_d.aux_trigger = 1'b0;
		// Suppression is sampled in the same cycle as the frequency write.
		if (freq_reg_write && !st_q.aux[`PACR_AX_NOTRIG]) begin
			st_d.aux_trigger = 1'b1;
		end
		// Capture halves of a write in either order.
		have_aw = st_q.aw_held || aw_fire;
		have_w  = st_q.w_held || w_fire;
		widx    = st_q.aw_held ? st_q.aw_idx : addr_to_idx(s_axi_awaddr);
		wdat    = st_q.w_held ? st_q.w_data : s_axi_wdata;
		wstb    = st_q.w_held ? st_q.w_strb : s_axi_wstrb;
		if (aw_fire) begin
			st_d.aw_held = 1'b1;
			st_d.aw_idx  = addr_to_idx(s_axi_awaddr);
		end
		if (w_fire) begin
			st_d.w_held = 1'b1;
			st_d.w_data = s_axi_wdata;
			st_d.w_strb = s_axi_wstrb;
		end
		case (st_q.wr_state)
			pacr_pkg::WR_IDLE: begin
				if (have_aw && have_w) begin
					st_d.aw_held  = 1'b0;
					st_d.w_held   = 1'b0;
					st_d.wr_state = pacr_pkg::WR_RESP;
					st_d.bresp    = idx_mapped(widx) ? `PACR_RESP_OKAY : `PACR_RESP_SLVERR;
					// Storage updates; every field holds exactly what was written.
					case (widx)
						`PACR_IDX_ANALOG: st_d.analog = merge24(st_q.analog, wdat, wstb,
							`PACR_MASK_ANALOG);
						`PACR_IDX_PUMP:   st_d.pump = merge24(st_q.pump, wdat, wstb,
							`PACR_MASK_PUMP);
						`PACR_IDX_AUX:    st_d.aux = 17'(merge24(aux_wide, wdat, wstb,
							{7'h00, `PACR_MASK_AUX}));
						`PACR_IDX_DET:    st_d.det = merge24(st_q.det, wdat, wstb,
							`PACR_MASK_DET);
						default: begin
						end
					endcase
				end
			end
			pacr_pkg::WR_RESP: begin
				if (s_axi_bready) begin
					st_d.wr_state = pacr_pkg::WR_IDLE;
				end
			end
			default: begin
				st_d.wr_state = pacr_pkg::WR_IDLE;
			end
		endcase
		// Read side: one-cycle latency, data held until taken.
		if (st_q.rvalid && s_axi_rready) begin
			st_d.rvalid = 1'b0;
		end
		if (ar_fire) begin
			st_d.rvalid = 1'b1;
			st_d.rdata  = read_idx(addr_to_idx(s_axi_araddr), st_q);
			st_d.rresp  = idx_mapped(addr_to_idx(s_axi_araddr)) ?
				`PACR_RESP_OKAY : `PACR_RESP_SLVERR;
		end
	end

	// State register; reset loads the documented defaults.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q.analog      <= `PACR_RST_ANALOG;
			st_q.pump        <= `PACR_RST_PUMP;
			st_q.aux         <= `PACR_RST_AUX;
			st_q.det         <= `PACR_RST_DET;
			st_q.wr_state    <= pacr_pkg::WR_IDLE;
			st_q.aw_held     <= 1'b0;
			st_q.w_held      <= 1'b0;
			st_q.aw_idx      <= 8'h00;
			st_q.w_data      <= 32'h00000000;
			st_q.w_strb      <= 4'h0;
			st_q.bresp       <= `PACR_RESP_OKAY;
			st_q.rvalid      <= 1'b0;
			st_q.rdata       <= 32'h00000000;
			st_q.rresp       <= `PACR_RESP_OKAY;
			st_q.aux_trigger <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	assign s_axi_bvalid = (st_q.wr_state == pacr_pkg::WR_RESP);
	assign s_axi_bresp  = st_q.bresp;
	assign s_axi_rvalid = st_q.rvalid;
	assign s_axi_rdata  = st_q.rdata;
	assign s_axi_rresp  = st_q.rresp;
	assign auxiliary_serial_port_start = st_q.aux_trigger;

	// Decoded settings toward the analog sections, all from flip-flops; high gain and the detector outputs pass one gate.
	always_comb begin
		logic fu;
		logic fd;
		fu = st_q.det[`PACR_DT_FRC_UP];
		fd = st_q.det[`PACR_DT_FRC_DN];
		analog_settings.bias_enable           = st_q.analog[`PACR_AN_BIAS];
		analog_settings.pump_enable           = st_q.analog[`PACR_AN_PUMP];
		analog_settings.phase_detector_enable = st_q.analog[`PACR_AN_DET];
		analog_settings.ref_buffer_enable     = st_q.analog[`PACR_AN_REFBUF];
		analog_settings.vco_buffer_enable     = st_q.analog[`PACR_AN_VCOBUF];
		analog_settings.divided_clock_to_logic_enable = st_q.analog[`PACR_AN_DIVCLK];
		analog_settings.prescaler_clock_enable = st_q.analog[`PACR_AN_PSCLK];
		analog_settings.prescaler_bias_enable  = st_q.analog[`PACR_AN_PSBIAS];
		analog_settings.pump_opamp_enable      = st_q.analog[`PACR_AN_OPAMP];
		analog_settings.rf_buffer_bias = st_q.analog[`PACR_AN_RFBUF_LO +: 3];
		analog_settings.resync_bias    = st_q.analog[`PACR_AN_RESYN_LO +: 3];
		analog_settings.half_band_divider_enable = st_q.analog[`PACR_AN_DIV2];
		// Passed through as set; the crystal rate is software's to know.
		analog_settings.high_freq_reference = st_q.analog[`PACR_AN_HIREF];
		analog_settings.pump_down_gain   = st_q.pump[`PACR_PU_DN_LO +: 7];
		analog_settings.pump_up_gain     = st_q.pump[`PACR_PU_UP_LO +: 7];
		analog_settings.pump_offset      = st_q.pump[`PACR_PU_OFS_LO +: 7];
		analog_settings.pump_offset_up   = st_q.pump[`PACR_PU_OFS_UP];
		analog_settings.pump_offset_down = st_q.pump[`PACR_PU_OFS_DN];
		// High gain only takes effect while the pump opamp is powered.
		analog_settings.high_gain_pump_mode = st_q.pump[`PACR_PU_HIGAIN] &
			st_q.analog[`PACR_AN_OPAMP];
		analog_settings.ref_divider_bypass = st_q.aux[`PACR_AX_BYPASS];
		analog_settings.detector_reset_delay = st_q.det[`PACR_DT_DELAY_LO +: 3];
		analog_settings.detector_inputs_shorted = st_q.det[`PACR_DT_SHORT];
		analog_settings.detector_polarity_flip  = st_q.det[`PACR_DT_FLIP];
		// A force turns its output on even when the enable is clear.
		analog_settings.detector_up_out = st_q.det[`PACR_DT_UP_EN] | fu;
		analog_settings.detector_down_out = st_q.det[`PACR_DT_DN_EN] | fd;
		analog_settings.slip_guard_mode = st_q.det[`PACR_DT_SLIP_LO +: 2];
		analog_settings.pump_mid_rail   = st_q.det[`PACR_DT_MIDRAIL];
		analog_settings.prescaler_bias_level = st_q.det[`PACR_DT_PSB_LO +: 3];
		analog_settings.opamp_bias           = st_q.det[`PACR_DT_OPB_LO +: 2];
		analog_settings.main_counter_gating  = st_q.det[`PACR_DT_GATE_LO +: 2];
		analog_settings.divider_pulse_width  = st_q.det[`PACR_DT_PW_LO +: 2];
	end

	// Pad driver enable for the combined lock/serial output pin.
	assign output_pad_enable = st_q.analog[`PACR_AN_PAD];

endmodule

`default_nettype wire

// ==== verif/pacr_regs_properties.sv ====
// Concurrent checks on the ports of the synthesizer control bank.
// Assumes one clock and a synchronous active-low reset; bound to every pacr_regs instance.
`timescale 1ns/1ps
`default_nettype none
module pacr_regs_properties (
	input wire logic                  aclk,
	input wire logic                  aresetn,
	input wire logic [31:0]           s_axi_awaddr,
	input wire logic                  s_axi_awvalid,
	input wire logic                  s_axi_awready,
	input wire logic [31:0]           s_axi_wdata,
	input wire logic [3:0]            s_axi_wstrb,
	input wire logic                  s_axi_wvalid,
	input wire logic                  s_axi_wready,
	input wire logic                  s_axi_bvalid,
	input wire logic [31:0]           s_axi_rdata,
	input wire logic                  s_axi_rvalid,
	input wire logic                  s_axi_rready,
	input wire pacr_pkg::pacr_analog_s analog_settings,
	input wire logic                  output_pad_enable,
	input wire logic                  freq_reg_write,
	input wire logic                  auxiliary_serial_port_start
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Only writes whose halves are taken together are judged, so split writes never misfire.
	logic       wr_go;
	logic [7:0] idx;
	assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	assign idx   = s_axi_awaddr[9:2];

	a_pad_write: assert property (
		wr_go && idx == 8'h08 && s_axi_wstrb[0] |=> output_pad_enable == $past(s_axi_wdata[5]))
		else $error("pad enable does not follow the write");
	a_analog_fields: assert property (
		wr_go && idx == 8'h08 && s_axi_wstrb[2:0] == 3'h7 |=>
		analog_settings.bias_enable == $past(s_axi_wdata[0])
		&& analog_settings.rf_buffer_bias == $past(s_axi_wdata[14:12])
		&& analog_settings.resync_bias == $past(s_axi_wdata[17:15])
		&& analog_settings.half_band_divider_enable == $past(s_axi_wdata[19])
		&& analog_settings.high_freq_reference == $past(s_axi_wdata[21]))
		else $error("analog fields do not follow the write");
	a_pump_fields: assert property (
		wr_go && idx == 8'h09 && s_axi_wstrb[2:0] == 3'h7 |=>
		analog_settings.pump_down_gain == $past(s_axi_wdata[6:0])
		&& analog_settings.pump_up_gain == $past(s_axi_wdata[13:7])
		&& analog_settings.pump_offset == $past(s_axi_wdata[20:14])
		&& analog_settings.pump_offset_down == $past(s_axi_wdata[22]))
		else $error("pump fields do not follow the write");
	a_hik_needs_opamp: assert property (
		analog_settings.high_gain_pump_mode |-> analog_settings.pump_opamp_enable)
		else $error("high gain mode without the opamp");
	a_bypass_write: assert property (
		wr_go && idx == 8'h0a && s_axi_wstrb[2] |=>
		analog_settings.ref_divider_bypass == $past(s_axi_wdata[16]))
		else $error("divider bypass does not follow the write");
	a_det_outputs: assert property (
		wr_go && idx == 8'h0b && s_axi_wstrb[1:0] == 2'h3 |=>
		analog_settings.detector_up_out == $past(s_axi_wdata[5] | s_axi_wdata[9])
		&& analog_settings.detector_down_out == $past(s_axi_wdata[6] | s_axi_wdata[10])
		&& analog_settings.detector_inputs_shorted == $past(s_axi_wdata[3])
		&& analog_settings.detector_polarity_flip == $past(s_axi_wdata[4]))
		else $error("detector outputs do not follow the write");
	a_det_codes: assert property (
		wr_go && idx == 8'h0b && s_axi_wstrb[2:0] == 3'h7 |=>
		analog_settings.detector_reset_delay == $past(s_axi_wdata[2:0])
		&& analog_settings.slip_guard_mode == $past(s_axi_wdata[8:7])
		&& analog_settings.prescaler_bias_level == $past(s_axi_wdata[14:12])
		&& analog_settings.main_counter_gating == $past(s_axi_wdata[18:17])
		&& analog_settings.divider_pulse_width == $past(s_axi_wdata[21:20]))
		else $error("detector codes do not follow the write");
	a_start_cause: assert property (
		auxiliary_serial_port_start |-> $past(freq_reg_write))
		else $error("transfer start without a register write");
	a_write_answer: assert property (
		wr_go |=> s_axi_bvalid)
		else $error("no write response one cycle after the write");
	a_read_holds: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before it was taken");
endmodule

bind pacr_regs pacr_regs_properties u_props (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .analog_settings(analog_settings),
	.output_pad_enable(output_pad_enable), .freq_reg_write(freq_reg_write),
	.auxiliary_serial_port_start(auxiliary_serial_port_start));
`default_nettype wire

// ==== verif/pacr_regs_tb_top.sv ====
// Self-checking bench for the synthesizer control bank, acting as the AXI4-Lite master.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module pacr_regs_tb_top;
	typedef struct packed {
		logic [7:0]  idx;
		logic [31:0] d;
		logic [3:0]  st;
		logic [31:0] exp;
		logic [1:0]  resp;
	} pacr_row_s;
	logic                   aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic                   s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic                   s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic                   output_pad_enable, freq_reg_write, auxiliary_serial_port_start;
	logic [31:0]            s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
	logic [3:0]             s_axi_wstrb;
	logic [1:0]             s_axi_bresp, s_axi_rresp, rs;
	logic [2:0]             s_axi_awprot, s_axi_arprot;
	pacr_pkg::pacr_analog_s analog_settings;
	int                     n_fail, compares;
	// Defaults in address order; spare bit 6 and reserved 22, 23 of the analog bank reset high.
	logic [31:0]            dflt [4] = '{32'h00c1beff, 32'h0040050a, 32'h0, 32'h000f8061};
	// Ordinary cases: each row writes, then reads back; an unmapped index answers an error.
	pacr_row_s              rows [6] = '{
		'{8'h08, 32'h12aa5678, 4'hf, 32'h00aa5678, 2'h0},
		'{8'h09, 32'h00ffffff, 4'hf, 32'h00ffffff, 2'h0},
		'{8'h09, 32'h00000000, 4'h2, 32'h00ff00ff, 2'h0},
		'{8'h0a, 32'hffffffff, 4'hf, 32'h0001ffff, 2'h0},
		'{8'h0b, 32'h00abcdef, 4'hf, 32'h00abcdef, 2'h0},
		'{8'h0c, 32'hffffffff, 4'hf, 32'h00000000, 2'h2}};

	pacr_regs u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.analog_settings, .output_pad_enable, .freq_reg_write, .auxiliary_serial_port_start);

	// Free-running 100 MHz clock.
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Address and data are offered together; each is dropped at the edge that takes it.
	task automatic axi_wr(input logic [7:0] i, input logic [31:0] d, input logic [3:0] st);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= {22'h0, i, 2'h0};
		s_axi_wdata <= d;
		s_axi_wstrb <= st;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && s_axi_awready) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (!s_axi_bvalid) @(posedge aclk);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] i);
		@(posedge aclk);
		s_axi_araddr <= {22'h0, i, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic check_defaults();
		for (int i = 0; i < 4; i++) begin
			axi_rd(8'h08 + 8'(i));
			chk("default", rd, dflt[i]);
		end
		chk("pad", 32'(output_pad_enable), 32'h1);
	endtask

	// Two register writes in a row; e is the start pulse expected after each.
	task automatic trig(input logic e);
		@(posedge aclk);
		freq_reg_write <= 1'b1;
		@(posedge aclk);
		#1 chk("start", 32'(auxiliary_serial_port_start), 32'(e));
		@(posedge aclk);
		freq_reg_write <= 1'b0;
		#1 chk("start", 32'(auxiliary_serial_port_start), 32'(e));
		@(posedge aclk);
		#1 chk("start", 32'(auxiliary_serial_port_start), 32'h0);
	endtask

	task automatic give_verdict();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// The whole sequence needs well under 3000 cycles.
	initial begin
		#200000;
		n_fail++;
		give_verdict();
	end

	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
		{s_axi_awprot, s_axi_arprot, freq_reg_write} = '0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		check_defaults();
		foreach (rows[k]) begin
			axi_wr(rows[k].idx, rows[k].d, rows[k].st);
			chk("bresp", 32'(rs), 32'(rows[k].resp));
			axi_rd(rows[k].idx);
			chk("rdata", rd, rows[k].exp);
			chk("rresp", 32'(rs), 32'(rows[k].resp));
		end
		// Analog bank with the pad off and every coded field away from its default.
		axi_wr(8'h08, 32'h0028f01f, 4'hf);
		chk("pad", 32'(output_pad_enable), 32'h0);
		chk("rfbuf", 32'(analog_settings.rf_buffer_bias), 32'h7);
		chk("resync", 32'(analog_settings.resync_bias), 32'h1);
		chk("div2", 32'(analog_settings.half_band_divider_enable), 32'h1);
		chk("hiref", 32'(analog_settings.high_freq_reference), 32'h1);
		axi_wr(8'h09, 32'h00800000, 4'hf);
		chk("hik", 32'(analog_settings.high_gain_pump_mode), 32'h0);
		chk("ofsdn", 32'(analog_settings.pump_offset_down), 32'h0);
		axi_wr(8'h08, 32'h0028f81f, 4'hf);
		chk("hik", 32'(analog_settings.high_gain_pump_mode), 32'h1);
		// Forces override cleared output enables.
		axi_wr(8'h0b, 32'h00000618, 4'hf);
		chk("up", 32'(analog_settings.detector_up_out), 32'h1);
		chk("dn", 32'(analog_settings.detector_down_out), 32'h1);
		chk("short", 32'(analog_settings.detector_inputs_shorted), 32'h1);
		chk("flip", 32'(analog_settings.detector_polarity_flip), 32'h1);
		axi_wr(8'h0b, 32'h00000800, 4'hf);
		chk("up", 32'(analog_settings.detector_up_out), 32'h0);
		chk("mid", 32'(analog_settings.pump_mid_rail), 32'h1);
		for (int m = 0; m < 4; m++) begin
			axi_wr(8'h0b, (m << 7) | (m << 12) | (m << 17) | (m << 20), 4'hf);
			chk("slip", 32'(analog_settings.slip_guard_mode), m);
			chk("psbias", 32'(analog_settings.prescaler_bias_level), m);
			chk("gate", 32'(analog_settings.main_counter_gating), m);
			chk("width", 32'(analog_settings.divider_pulse_width), m);
		end
		// Transfer trigger, then its suppression, then the divider bypass.
		axi_wr(8'h0a, 32'h0, 4'hf);
		trig(1'b1);
		axi_wr(8'h0a, 32'h00001000, 4'hf);
		trig(1'b0);
		axi_wr(8'h0a, 32'h00010000, 4'hf);
		chk("bypass", 32'(analog_settings.ref_divider_bypass), 32'h1);
		trig(1'b1);
		// A read left waiting two cycles must hold its answer until it is taken.
		@(posedge aclk);
		s_axi_araddr  <= 32'h0000002c;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		repeat (2) @(posedge aclk);
		s_axi_rready  <= 1'b1;
		do @(posedge aclk); while (!s_axi_rvalid);
		chk("late rdata", s_axi_rdata, 32'h00363180);
		s_axi_rready  <= 1'b0;
		// Data offered before its address; the write lands at the edge that takes the address, with the data held.
		@(posedge aclk);
		s_axi_wdata   <= 32'h00000005;
		s_axi_wstrb   <= 4'hf;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do @(posedge aclk); while (!s_axi_wready);
		s_axi_wvalid  <= 1'b0;
		s_axi_awaddr  <= 32'h0000002c;
		s_axi_awvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_awready);
		s_axi_awvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_bvalid);
		chk("split bresp", 32'(s_axi_bresp), 32'h0);
		s_axi_bready  <= 1'b0;
		chk("split delay", 32'(analog_settings.detector_reset_delay), 32'h5);
		// A second reset in mid-run brings every register back to its default.
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		check_defaults();
		give_verdict();
	end
endmodule
`default_nettype wire
